// ### ext_irq_edge.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// External interrupt zero falling-edge detector
// ---------------------------------------------------------------
module ext_irq_edge (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ext_irq_zero_pin,
  input wire logic slow_mode,
  input wire logic strobe,
  output logic edge_event
);
  import lpm_pkg::*;

  logic sync1_reg, sync2_reg, sync3_reg;
  logic level_reg, level_next;
  logic sample_reg, sample_next;
  logic event_reg, event_next;
  logic sample_now;
  logic fall;

  // Sampling clock: frame strobe when slow, every cycle otherwise
  assign sample_now = slow_mode ? strobe : 1'b1;
  assign fall = sample_now && sample_reg && !level_reg;

  // Filtered level, sample history and edge pulse
  always_comb begin
    level_next = (sync2_reg == sync3_reg) ? sync3_reg : level_reg;
    sample_next = sample_now ? level_reg : sample_reg;
    event_next = fall; // RULE_18
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      level_reg <= 1'b1;
      sample_reg <= 1'b1;
      event_reg <= 1'b0;
    end else begin
      sync1_reg <= ext_irq_zero_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
      sample_reg <= sample_next;
      event_reg <= event_next;
    end
  end

  assign edge_event = event_reg;

endmodule : ext_irq_edge

// ### ext_pin_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// External interrupt pin driver
// ---------------------------------------------------------------
module ext_pin_model #(
  parameter int HOLD_CYCLES = 40
) (
  input wire logic core_clk,
  input wire logic fall_req,
  output logic ext_irq_zero_pin
);
  int low_cnt = 0;

  // Idle high, then low for longer than one frame on request
  always @(posedge core_clk) begin
    if (fall_req) begin
      low_cnt <= HOLD_CYCLES;
    end else if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
    end
  end
  assign ext_irq_zero_pin = (low_cnt == 0);
endmodule : ext_pin_model

// ### frame_strobe_gen.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Interrupt frame strobe generator
// ---------------------------------------------------------------
module frame_strobe_gen #(
  parameter int CNT_W = 16,
  parameter int FRAME0_CYCLES = lpm_pkg::FRAME0_CYCLES,
  parameter int FRAME1_CYCLES = lpm_pkg::FRAME1_CYCLES,
  parameter int FRAME2_CYCLES = lpm_pkg::FRAME2_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] frame_sel,
  output logic strobe
);
  import lpm_pkg::*;

  logic [CNT_W-1:0] count_reg, count_next;
  logic strobe_reg, strobe_next;

  // Frame length from the select code
  function automatic logic [CNT_W-1:0] frame_last(input logic [1:0] sel);
    if (sel == 2'h0) begin
      frame_last = CNT_W'(FRAME0_CYCLES - 1);
    end else if (sel == 2'h1) begin
      frame_last = CNT_W'(FRAME1_CYCLES - 1);
    end else begin
      frame_last = CNT_W'(FRAME2_CYCLES - 1);
    end
  endfunction : frame_last

  // Free-running frame counter, strobe at wrap
  always_comb begin
    count_next = count_reg + CNT_W'(1);
    strobe_next = 1'b0;
    if (count_reg >= frame_last(frame_sel)) begin
      count_next = '0;
      strobe_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_reg <= '0;
      strobe_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      strobe_reg <= strobe_next;
    end
  end

  assign strobe = strobe_reg;

endmodule : frame_strobe_gen

// ### low_power_mode_sequencer.sv
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
// How it works
// [RULE_01] Watch exits only by reset or timer/edge request
// [RULE_02] Wake target: active if slow flag 0, else subactive
// [RULE_03] Timer wake settle; edge wake one to two frames more
// [RULE_04] Subactive sleep goes to watch or active
// [RULE_05] Direct flag settable only in subactive, self-clears
// [RULE_06] Direct flag at bit 3, reads zero in active
// [RULE_07] Slow-mode requests follow selectable interrupt frame
// [RULE_08] Request comes one settle time after its strobe
// [RULE_09] Falling edge counts at second strobe after it
// [RULE_10] Slow-mode timer overflow aligned to strobe
// [RULE_11] Direct transfer: slow 0, direct 1, then sleep
// [RULE_12] Direct transfer between settle and frame plus settle
// [RULE_13] Reset works from every mode
// [RULE_14] Sleep with pending unmasked flag and IE clear: no-op
// [RULE_15] Software clears or masks flags before sleep
// [RULE_16] Sleep on strobe in subactive drops pending requests
// [RULE_17] Software avoids sleep on the strobe
// [RULE_18] Edge when consecutive samples go high to low
// [RULE_19] Pin high and low each longer than one frame
// [RULE_20] Software matches oscillator bit to main frequency
// [RULE_21] Main oscillator outside 1.0 to 1.6 MHz band
// [RULE_22] Subactive clocks CPU from subclock
// [RULE_23] Watch from active stop with timebase bit, or subactive
// [RULE_24] Wake resumes after sleep; IE decides servicing
// [RULE_25] Direct only for slow 0 and direct 1, else watch
module low_power_mode_sequencer #(
  parameter int CNT_W = 16,
  parameter int SETTLE_CYCLES = lpm_pkg::OSC_SETTLE_CYCLES,
  parameter int FRAME0_CYCLES = lpm_pkg::FRAME0_CYCLES,
  parameter int FRAME1_CYCLES = lpm_pkg::FRAME1_CYCLES,
  parameter int FRAME2_CYCLES = lpm_pkg::FRAME2_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [lpm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [lpm_pkg::DATA_W-1:0] avs_writedata,
  output logic [lpm_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stop_instruction,
  input wire logic standby_instruction,
  input wire logic global_irq_enable,
  input wire logic irq_pending_unmasked,
  input wire logic standby_wake_irq,
  input wire logic timebase_select_bit,
  input wire logic timer_a_overflow,
  input wire logic ext_irq_zero_pin,
  output logic timer_a_request_flag,
  output logic ext_irq_zero_request_flag,
  output logic sleep_nop,
  output logic resume_pulse,
  output logic sub_clock_sel,
  output logic cpu_clock_run,
  output logic main_osc_run,
  output logic osc_freq_select,
  output logic so_pmos_off
);
  import lpm_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  mode_t mode_reg, mode_next;
  logic [REG_W-1:0] misc_reg, misc_next;
  logic slow_flag_reg, slow_flag_next;
  logic direct_flag_reg, direct_flag_next;
  logic settling_reg, settling_next;
  logic [CNT_W-1:0] settle_cnt_reg, settle_cnt_next;
  logic tmr_pend_reg, tmr_pend_next;
  logic ext_pend_reg, ext_pend_next;
  logic tmr_launch_reg, tmr_launch_next;
  logic ext_launch_reg, ext_launch_next;
  logic tmr_req_reg, tmr_req_next;
  logic ext_req_reg, ext_req_next;
  logic nop_reg, nop_next;
  logic resume_reg, resume_next;
  logic sub_clk_reg, osc_run_reg, cpu_run_reg;
  logic waitreq_reg, waitreq_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  logic strobe;
  logic edge_event;
  logic slow_mode;
  logic sleep_req;
  logic nop_cond;
  logic settle_done;
  logic bus_take;
  logic wr_misc;
  logic wr_mode;

  // ---------------------------------------------------------------
  // Frame strobe and edge detection
  // ---------------------------------------------------------------
  assign slow_mode = (mode_reg == MODE_WATCH) || (mode_reg == MODE_SUBACTIVE)
                     || (mode_reg == MODE_DIRECT);

  frame_strobe_gen #(
    .CNT_W(CNT_W),
    .FRAME0_CYCLES(FRAME0_CYCLES),
    .FRAME1_CYCLES(FRAME1_CYCLES),
    .FRAME2_CYCLES(FRAME2_CYCLES)
  ) u_frame (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .frame_sel(misc_reg[MISC_FRAME_LSB +: 2]), // RULE_07
    .strobe(strobe)
  );

  ext_irq_edge u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ext_irq_zero_pin(ext_irq_zero_pin),
    .slow_mode(slow_mode),
    .strobe(strobe),
    .edge_event(edge_event)
  );

  // ---------------------------------------------------------------
  // Avalon slave, one wait cycle per access
  // ---------------------------------------------------------------
  assign bus_take = (avs_read || avs_write) && !waitreq_reg;
  assign wr_misc = bus_take && avs_write && (avs_address == MISC_CONTROL_OFFSET);
  assign wr_mode = bus_take && avs_write && (avs_address == MODE_CONTROL_OFFSET);

  // Wait state and read data capture
  always_comb begin
    waitreq_next = !((avs_read || avs_write) && waitreq_reg);
    rdata_next = rdata_reg;
    if (avs_read && waitreq_reg) begin
      rdata_next = '0;
      unique case (avs_address)
        MISC_CONTROL_OFFSET: rdata_next[REG_W-1:0] = misc_reg;
        MODE_CONTROL_OFFSET: begin
          rdata_next[SLOW_FLAG_BIT] = slow_flag_reg;
          rdata_next[DIRECT_FLAG_BIT] = direct_flag_reg && (mode_reg != MODE_ACTIVE); // RULE_06
        end
        MODE_STATUS_OFFSET: rdata_next[2:0] = mode_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      waitreq_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      waitreq_reg <= waitreq_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  assign sleep_req = stop_instruction || standby_instruction;
  assign nop_cond = sleep_req && !global_irq_enable && irq_pending_unmasked; // RULE_14
  assign settle_done = settling_reg && (settle_cnt_reg == '0);

  // Next mode, flags, settle timer and request pulses
  always_comb begin
    mode_next = mode_reg;
    misc_next = wr_misc ? avs_writedata[REG_W-1:0] : misc_reg;
    slow_flag_next = wr_mode ? avs_writedata[SLOW_FLAG_BIT] : slow_flag_reg;
    direct_flag_next = direct_flag_reg;
    if (wr_mode && mode_reg == MODE_SUBACTIVE) begin
      direct_flag_next = avs_writedata[DIRECT_FLAG_BIT]; // RULE_05
    end
    settling_next = settling_reg;
    settle_cnt_next = settle_cnt_reg;
    tmr_pend_next = tmr_pend_reg;
    ext_pend_next = ext_pend_reg;
    tmr_launch_next = tmr_launch_reg;
    ext_launch_next = ext_launch_reg;
    tmr_req_next = 1'b0;
    ext_req_next = 1'b0;
    nop_next = 1'b0;
    resume_next = 1'b0;
    if (settling_reg && !settle_done) begin
      settle_cnt_next = settle_cnt_reg - CNT_W'(1);
    end
    unique case (mode_reg)
      MODE_ACTIVE: begin
        direct_flag_next = 1'b0; // RULE_06
        tmr_req_next = timer_a_overflow;
        ext_req_next = edge_event;
        if (nop_cond) begin
          nop_next = 1'b1; // RULE_14
        end else if (standby_instruction) begin
          mode_next = MODE_STANDBY;
        end else if (stop_instruction) begin
          mode_next = timebase_select_bit ? MODE_WATCH : MODE_STOP; // RULE_23
        end
      end
      MODE_STANDBY: begin
        tmr_req_next = timer_a_overflow;
        ext_req_next = edge_event;
        if (standby_wake_irq || timer_a_overflow || edge_event) begin
          mode_next = MODE_ACTIVE;
          resume_next = 1'b1; // RULE_24
        end
      end
      MODE_STOP: begin
        mode_next = MODE_STOP; // RULE_13
      end
      MODE_WATCH, MODE_SUBACTIVE, MODE_DIRECT: begin
        // Events wait for the frame strobe
        tmr_pend_next = tmr_pend_reg || timer_a_overflow; // RULE_10
        ext_pend_next = ext_pend_reg || edge_event; // RULE_07
        if (mode_reg == MODE_DIRECT) begin
          if (strobe && !settling_reg) begin
            settling_next = 1'b1; // RULE_12
            settle_cnt_next = CNT_W'(SETTLE_CYCLES - 1);
          end else if (settle_done) begin
            settling_next = 1'b0;
            mode_next = MODE_ACTIVE; // RULE_11
            direct_flag_next = 1'b0; // RULE_05
            resume_next = 1'b1; // RULE_24
            tmr_req_next = tmr_pend_reg || tmr_launch_reg || timer_a_overflow; // RULE_08
            ext_req_next = ext_pend_reg || ext_launch_reg || edge_event;
            tmr_pend_next = 1'b0;
            ext_pend_next = 1'b0;
            tmr_launch_next = 1'b0;
            ext_launch_next = 1'b0;
          end
        end else begin
          if (settle_done) begin
            settling_next = 1'b0;
            tmr_req_next = tmr_launch_reg; // RULE_08
            ext_req_next = ext_launch_reg;
            tmr_launch_next = 1'b0;
            ext_launch_next = 1'b0;
            if (mode_reg == MODE_WATCH) begin
              mode_next = slow_flag_reg ? MODE_SUBACTIVE : MODE_ACTIVE; // RULE_02
              resume_next = !slow_flag_reg; // RULE_03
            end
          end else if (strobe && !settling_reg && (tmr_pend_next || ext_pend_next)) begin
            settling_next = 1'b1; // RULE_01
            settle_cnt_next = CNT_W'(SETTLE_CYCLES - 1);
            tmr_launch_next = tmr_pend_next;
            ext_launch_next = ext_pend_next; // RULE_09
            tmr_pend_next = 1'b0;
            ext_pend_next = 1'b0;
          end
          if (mode_reg == MODE_SUBACTIVE && sleep_req) begin
            if (nop_cond) begin
              nop_next = 1'b1; // RULE_14
            end else begin
              if (strobe) begin
                tmr_pend_next = 1'b0; // RULE_16
                ext_pend_next = 1'b0;
                tmr_launch_next = 1'b0;
                ext_launch_next = 1'b0;
                settling_next = 1'b0;
              end
              if (!slow_flag_reg && direct_flag_reg) begin
                mode_next = MODE_DIRECT; // RULE_25
                settling_next = 1'b0;
              end else begin
                mode_next = MODE_WATCH; // RULE_04
              end
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_reg <= MODE_ACTIVE; // RULE_13
      misc_reg <= MISC_CONTROL_RESET;
      slow_flag_reg <= MODE_CONTROL_RESET[SLOW_FLAG_BIT];
      direct_flag_reg <= MODE_CONTROL_RESET[DIRECT_FLAG_BIT];
      settling_reg <= 1'b0;
      settle_cnt_reg <= '0;
      tmr_pend_reg <= 1'b0;
      ext_pend_reg <= 1'b0;
      tmr_launch_reg <= 1'b0;
      ext_launch_reg <= 1'b0;
      tmr_req_reg <= 1'b0;
      ext_req_reg <= 1'b0;
      nop_reg <= 1'b0;
      resume_reg <= 1'b0;
      sub_clk_reg <= 1'b0;
      osc_run_reg <= 1'b1;
      cpu_run_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      misc_reg <= misc_next;
      slow_flag_reg <= slow_flag_next;
      direct_flag_reg <= direct_flag_next;
      settling_reg <= settling_next;
      settle_cnt_reg <= settle_cnt_next;
      tmr_pend_reg <= tmr_pend_next;
      ext_pend_reg <= ext_pend_next;
      tmr_launch_reg <= tmr_launch_next;
      ext_launch_reg <= ext_launch_next;
      tmr_req_reg <= tmr_req_next;
      ext_req_reg <= ext_req_next;
      nop_reg <= nop_next;
      resume_reg <= resume_next;
      sub_clk_reg <= (mode_next == MODE_SUBACTIVE); // RULE_22
      osc_run_reg <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_STANDBY)
                     || (mode_next == MODE_DIRECT) || settling_next;
      cpu_run_reg <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_SUBACTIVE);
    end
  end

  // Outputs straight from flops
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = waitreq_reg;
  assign timer_a_request_flag = tmr_req_reg;
  assign ext_irq_zero_request_flag = ext_req_reg;
  assign sleep_nop = nop_reg;
  assign resume_pulse = resume_reg;
  assign sub_clock_sel = sub_clk_reg;
  assign cpu_clock_run = cpu_run_reg;
  assign main_osc_run = osc_run_reg;
  assign osc_freq_select = misc_reg[MISC_OSC_FREQ_BIT];
  assign so_pmos_off = misc_reg[MISC_SO_PMOS_OFF_BIT];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_watch_exit_cause: assert property (mode_reg == MODE_WATCH && !settle_done
    && !sleep_req |=> mode_reg == MODE_WATCH) else $error("watch left without cause"); // RULE_01
  a_watch_wake_target: assert property (mode_reg == MODE_WATCH && settle_done |=>
    mode_reg == ($past(slow_flag_reg) ? MODE_SUBACTIVE : MODE_ACTIVE))
    else $error("wrong wake target"); // RULE_02
  a_stop_holds: assert property (mode_reg == MODE_STOP |=> mode_reg == MODE_STOP)
    else $error("stop left without reset"); // RULE_13
  a_direct_set_sub: assert property ($rose(direct_flag_reg) |-> $past(mode_reg) == MODE_SUBACTIVE)
    else $error("direct flag set outside subactive"); // RULE_05
  a_direct_active_zero: assert property (mode_reg == MODE_ACTIVE |-> !direct_flag_reg)
    else $error("direct flag set in active"); // RULE_06
  a_sub_sleep_target: assert property (mode_reg == MODE_SUBACTIVE && sleep_req && !nop_cond |=>
    mode_reg == (($past(slow_flag_reg) == 1'b0 && $past(direct_flag_reg)) ? MODE_DIRECT : MODE_WATCH))
    else $error("wrong subactive sleep target"); // RULE_25
  a_nop_keeps_mode: assert property (mode_reg == MODE_ACTIVE && nop_cond |=>
    sleep_nop && mode_reg == MODE_ACTIVE) else $error("sleep not cancelled"); // RULE_14
  a_strobe_sleep_drop: assert property (mode_reg == MODE_SUBACTIVE && sleep_req && !nop_cond
    && strobe |=> !tmr_pend_reg && !ext_pend_reg && !tmr_launch_reg ##1 !timer_a_request_flag)
    else $error("requests kept on strobe sleep"); // RULE_16
  a_slow_req_settled: assert property ($rose(timer_a_request_flag) && $past(mode_reg) == MODE_WATCH
    |-> $past(settle_done)) else $error("request before settle"); // RULE_08
  a_sub_clock_mode: assert property (sub_clock_sel == (mode_reg == MODE_SUBACTIVE))
    else $error("subclock select mismatch"); // RULE_22
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  c_watch_to_active: cover property (mode_reg == MODE_WATCH ##1 mode_reg == MODE_ACTIVE);
  c_direct_done: cover property (mode_reg == MODE_DIRECT ##1 mode_reg == MODE_ACTIVE);
  c_sleep_nop: cover property (sleep_nop);
  c_sub_entry: cover property (mode_reg == MODE_WATCH ##1 mode_reg == MODE_SUBACTIVE);

endmodule : low_power_mode_sequencer

// ### lpm_pkg.sv
// ---------------------------------------------------------------
// Shared constants of the low-power mode sequencer
// ---------------------------------------------------------------
package lpm_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 4;

  // Register byte offsets
  localparam logic [7:0] MISC_CONTROL_OFFSET = 8'h0c;
  localparam logic [7:0] MODE_CONTROL_OFFSET = 8'h20;
  localparam logic [7:0] MODE_STATUS_OFFSET = 8'h24;

  // Miscellaneous control fields
  localparam int MISC_FRAME_LSB = 0;
  localparam int MISC_SO_PMOS_OFF_BIT = 2;
  localparam int MISC_OSC_FREQ_BIT = 3;
  localparam logic [3:0] MISC_CONTROL_RESET = 4'h0;

  // Mode control fields
  localparam int SLOW_FLAG_BIT = 2;
  localparam int DIRECT_FLAG_BIT = 3;
  localparam logic [3:0] MODE_CONTROL_RESET = 4'h0;

  // Timing, core clock at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_SETTLE_TIME_US = 1000;
  localparam int FRAME0_TIME_US = 250;
  localparam int FRAME1_TIME_US = 500;
  localparam int FRAME2_TIME_US = 1000;
  localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME0_CYCLES = (FRAME0_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int FRAME1_CYCLES = (FRAME1_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int FRAME2_CYCLES = (FRAME2_TIME_US * 1000) / CLK_PERIOD_NS;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_STANDBY,
    MODE_STOP,
    MODE_WATCH,
    MODE_SUBACTIVE,
    MODE_DIRECT
  } mode_t;

endpackage : lpm_pkg

// ### test_low_power_mode_sequencer.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Testbench of the low-power mode sequencer
// ---------------------------------------------------------------
module test_low_power_mode_sequencer;
  import lpm_pkg::*;
  localparam int SETTLE = 20;
  localparam int FRAME1 = 16;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic stop_i = 1'b0;
  logic standby_i = 1'b0;
  logic ie = 1'b1;
  logic pend = 1'b0;
  logic tb_sel = 1'b0;
  logic ovf = 1'b0;
  logic fall_req = 1'b0;
  logic pin, ta_flag, ex_flag, nop, resume, sub_sel, cpu_run, osc_run, freq_sel, pmos_off;
  logic ta_seen = 1'b0;
  logic ex_seen = 1'b0;
  logic nop_seen = 1'b0;
  logic [31:0] rd;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;

  always #50 core_clk = ~core_clk;

  low_power_mode_sequencer #(.SETTLE_CYCLES(SETTLE), .FRAME0_CYCLES(8), .FRAME1_CYCLES(FRAME1),
    .FRAME2_CYCLES(32)) dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_instruction(stop_i),
    .standby_instruction(standby_i), .global_irq_enable(ie), .irq_pending_unmasked(pend),
    .standby_wake_irq(1'b0), .timebase_select_bit(tb_sel), .timer_a_overflow(ovf),
    .ext_irq_zero_pin(pin), .timer_a_request_flag(ta_flag), .ext_irq_zero_request_flag(ex_flag),
    .sleep_nop(nop), .resume_pulse(resume), .sub_clock_sel(sub_sel), .cpu_clock_run(cpu_run),
    .main_osc_run(osc_run), .osc_freq_select(freq_sel), .so_pmos_off(pmos_off));

  ext_pin_model #(.HOLD_CYCLES(40)) pin_drv (.core_clk(core_clk), .fall_req(fall_req),
    .ext_irq_zero_pin(pin));

  // Sticky capture of one-cycle pulses, mid-cycle
  always @(negedge core_clk) begin
    if (ta_flag === 1'b1) ta_seen <= 1'b1;
    if (ex_flag === 1'b1) ex_seen <= 1'b1;
    if (nop === 1'b1) nop_seen <= 1'b1;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task bus_write(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus_write

  task bus_read(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus_read

  task read_check(input logic [7:0] a, input logic [31:0] exp);
    bus_read(a, rd);
    check(rd, exp);
  endtask : read_check

  // One-cycle sleep pulse, then a few cycles to settle
  task sleep(input logic use_stop);
    while (dut.u_frame.strobe_next === 1'b1) @(posedge core_clk);
    if (use_stop) stop_i <= 1'b1;
    else standby_i <= 1'b1;
    @(posedge core_clk);
    stop_i <= 1'b0;
    standby_i <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : sleep

  // Count cycles until the wake resume pulse
  task wait_resume();
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (resume !== 1'b1 && n < 500);
  endtask : wait_resume

  task final_report();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // ---------------------------------------------------------------
    // Reset values and register access
    // ---------------------------------------------------------------
    read_check(MISC_CONTROL_OFFSET, 32'h0000_0000);
    read_check(8'h40, 32'h0000_0000);
    check({cpu_run, sub_sel, osc_run}, 32'h0000_0005);
    bus_write(MISC_CONTROL_OFFSET, 32'h0000_0005);
    @(posedge core_clk);
    check({freq_sel, pmos_off}, 32'h0000_0001);
    bus_write(MISC_CONTROL_OFFSET, 32'h0000_0009);
    @(posedge core_clk);
    check({freq_sel, pmos_off}, 32'h0000_0002);
    read_check(MISC_CONTROL_OFFSET, 32'h0000_0009);
    bus_write(MODE_CONTROL_OFFSET, 32'h0000_0008);
    read_check(MODE_CONTROL_OFFSET, 32'h0000_0000);
    // ---------------------------------------------------------------
    // Cancelled sleep, then watch and timer wake
    // ---------------------------------------------------------------
    ie <= 1'b0;
    pend <= 1'b1;
    tb_sel <= 1'b1;
    sleep(1'b1);
    check(nop_seen, 32'h0000_0001);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0000);
    pend <= 1'b0;
    sleep(1'b1);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0003);
    repeat (60) @(posedge core_clk);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0003);
    ovf <= 1'b1;
    @(posedge core_clk);
    ovf <= 1'b0;
    wait_resume();
    check(n >= SETTLE && n <= FRAME1 + SETTLE + 3, 32'h0000_0001);
    check(ta_seen, 32'h0000_0001);
    check(ex_seen, 32'h0000_0000);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0000);
    sleep(1'b0);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0001);
    ovf <= 1'b1;
    @(posedge core_clk);
    ovf <= 1'b0;
    wait_resume();
    check(n, 32'h0000_0001);
    // ---------------------------------------------------------------
    // Edge wake into subactive, sleep back to watch
    // ---------------------------------------------------------------
    bus_write(MODE_CONTROL_OFFSET, 32'h0000_0004);
    sleep(1'b1);
    fall_req <= 1'b1;
    @(posedge core_clk);
    fall_req <= 1'b0;
    n = 0;
    while (ex_flag !== 1'b1 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    check(n > FRAME1 + SETTLE && n < 2 * FRAME1 + SETTLE + 6, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0004);
    check({sub_sel, cpu_run}, 32'h0000_0003);
    sleep(1'b0);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0003);
    ovf <= 1'b1;
    @(posedge core_clk);
    ovf <= 1'b0;
    repeat (FRAME1 + SETTLE + 6) @(posedge core_clk);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0004);
    // ---------------------------------------------------------------
    // Direct transfer from subactive
    // ---------------------------------------------------------------
    bus_write(MODE_CONTROL_OFFSET, 32'h0000_0008);
    read_check(MODE_CONTROL_OFFSET, 32'h0000_0008);
    while (dut.u_frame.strobe_next === 1'b1) @(posedge core_clk);
    standby_i <= 1'b1;
    @(posedge core_clk);
    standby_i <= 1'b0;
    wait_resume();
    check(n > SETTLE && n < FRAME1 + SETTLE + 2, 32'h0000_0001);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0000);
    read_check(MODE_CONTROL_OFFSET, 32'h0000_0000);
    // ---------------------------------------------------------------
    // Stop mode left only by reset
    // ---------------------------------------------------------------
    tb_sel <= 1'b0;
    sleep(1'b1);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0002);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    read_check(MODE_STATUS_OFFSET, 32'h0000_0000);
    read_check(MISC_CONTROL_OFFSET, 32'h0000_0000);
    final_report();
  end
endmodule : test_low_power_mode_sequencer
